/* hdl/compare_and_custom_decode.sv */
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Functional notes
// - R-form: A, B, C, zero field, 0x3A
// - R-form 0x10: signed less-than to C
// - R-form 0x30: unsigned less-than to C
// - R-form 0x18: not-equal to C
// - I-form: A, B destination, 16-bit immediate
// - Immediate 0x10: sign-extend, signed less-than
// - Immediate 0x30: zero-extend, unsigned less-than
// - Immediate 0x18: sign-extend, not-equal
// - Opcode 0x32 reaches 256 custom functions
// - Eight-bit selector presented to user logic
// - Two operands; write C only if selected
// - Bits 16,15,14 mark general registers
// - Cleared bit means custom register file
module compare_and_custom_decode
(
	input  wire logic        i_clk,          // Clock, 40 MHz
	input  wire logic        i_reset,        // Sync reset, high
	input  wire logic        i_ce,           // Clock enable
	input  wire logic        i_psel,         // APB select
	input  wire logic        i_penable,      // APB enable
	input  wire logic        i_pwrite,       // APB write
	input  wire logic [7:0]  i_paddr,        // APB address
	input  wire logic [31:0] i_pwdata,       // APB write data
	output logic [31:0]      o_prdata,       // APB read data
	output logic             o_pready,       // APB ready
	output logic             o_pslverr,      // APB error
	input  wire logic        i_issue_valid,  // Instruction offered
	input  wire logic [31:0] i_instr,        // Instruction word
	input  wire logic [31:0] i_opa,          // General register A value
	input  wire logic [31:0] i_opb,          // General register B value
	output logic             o_issue_ready,  // Instruction taken
	output logic             o_wb_valid,     // Write-back pulse
	output logic [4:0]       o_wb_idx,       // Write-back register
	output logic [31:0]      o_wb_data,      // Write-back value
	output logic             o_unhandled,    // Word outside this slice
	output logic             o_ci_start,     // Custom start pulse
	output logic [7:0]       o_ci_n,         // Custom function selector
	output logic [31:0]      o_ci_dataa,     // Custom operand A
	output logic [31:0]      o_ci_datab,     // Custom operand B
	output logic [4:0]       o_ci_a,         // Custom index A
	output logic [4:0]       o_ci_b,         // Custom index B
	output logic [4:0]       o_ci_c,         // Custom index C
	output logic             o_ci_readra,    // A from general file
	output logic             o_ci_readrb,    // B from general file
	output logic             o_ci_writerc,   // C to general file
	input  wire logic        i_ci_done,      // Custom result pulse
	input  wire logic [31:0] i_ci_result     // Custom result
);

	typedef enum logic {ST_IDLE, ST_CUSTOM} state_t;

	// Five-bit register index at a given position
	function automatic logic [4:0] reg_idx(input logic [31:0] w, input int lsb);
		reg_idx = w[lsb +: 5];
	endfunction

	// Immediate extension, signed or zero
	function automatic logic [31:0] ext_imm(input logic [31:0] w, input logic sgn);
		logic [15:0] imm;
		imm     = w[cmp_decode_pkg::FLD_IMM_LSB +: 16];
		ext_imm = {{16{sgn & imm[15]}}, imm};
	endfunction

	state_t      state_r, state_nxt;        // Sequencer
	logic        ready_r, ready_nxt;        // Issue ready
	logic        wb_valid_r, wb_valid_nxt;  // Write-back strobe
	logic [4:0]  wb_idx_r, wb_idx_nxt;      // Write-back index
	logic [31:0] wb_data_r, wb_data_nxt;    // Write-back data
	logic        unh_r, unh_nxt;            // Unhandled strobe
	logic        start_r, start_nxt;        // Custom start
	logic [7:0]  n_r, n_nxt;                // Custom selector
	logic [31:0] da_r, da_nxt;              // Custom operand A
	logic [31:0] db_r, db_nxt;              // Custom operand B
	logic [4:0]  ca_r, ca_nxt;              // Custom index A
	logic [4:0]  cb_r, cb_nxt;              // Custom index B
	logic [4:0]  cc_r, cc_nxt;              // Custom index C
	logic        rra_r, rra_nxt;            // Read A general
	logic        rrb_r, rrb_nxt;            // Read B general
	logic        wrc_r, wrc_nxt;            // Write C general
	logic        enable;                    // Control enable
	logic        accept;                    // Word taken this cycle
	logic [5:0]  opc;                       // Primary opcode
	logic [5:0]  opx;                       // Extended opcode
	logic        is_cmp;                    // Word is a compare
	logic        is_ci;                     // Word is custom
	cmp_decode_pkg::cmp_op_t cmp_op;        // Compare kind
	logic [31:0] cmp_b;                     // Second compare operand
	logic [4:0]  cmp_dst;                   // Compare destination
	logic        cmp_hit;                   // Compare outcome

	// Instruction decode
	always_comb
	begin
		opc     = i_instr[5:0];
		opx     = i_instr[cmp_decode_pkg::FLD_OPX_LSB +: 6];
		is_cmp  = 1'b0;
		is_ci   = 1'b0;
		cmp_op  = cmp_decode_pkg::CMP_LT;
		cmp_b   = i_opb;
		cmp_dst = reg_idx(i_instr, cmp_decode_pkg::FLD_C_LSB);
		accept  = i_issue_valid && ready_r;
		if (opc == cmp_decode_pkg::OPC_RTYPE &&
		    i_instr[cmp_decode_pkg::FLD_ZERO_LSB +: 5] == 5'h00)
		begin
			is_cmp = 1'b1;
			case (opx)
				cmp_decode_pkg::OPX_LT:  cmp_op = cmp_decode_pkg::CMP_LT;
				cmp_decode_pkg::OPX_LTU: cmp_op = cmp_decode_pkg::CMP_LTU;
				cmp_decode_pkg::OPX_NE:  cmp_op = cmp_decode_pkg::CMP_NE;
				default:                 is_cmp = 1'b0;
			endcase
		end
		else
		begin
			cmp_dst = reg_idx(i_instr, cmp_decode_pkg::FLD_B_LSB);
			case (opc)
				cmp_decode_pkg::OPC_LT_IMM:
				begin
					is_cmp = 1'b1;
					cmp_op = cmp_decode_pkg::CMP_LT;
					cmp_b  = ext_imm(i_instr, 1'b1);
				end
				cmp_decode_pkg::OPC_LTU_IMM:
				begin
					is_cmp = 1'b1;
					cmp_op = cmp_decode_pkg::CMP_LTU;
					cmp_b  = ext_imm(i_instr, 1'b0);
				end
				cmp_decode_pkg::OPC_NE_IMM:
				begin
					is_cmp = 1'b1;
					cmp_op = cmp_decode_pkg::CMP_NE;
					cmp_b  = ext_imm(i_instr, 1'b1);
				end
				cmp_decode_pkg::OPC_CUSTOM: is_ci = 1'b1;
				default:                    is_cmp = 1'b0;
			endcase
		end
	end

	// Compare datapath
	cmp_unit u_cmp
	(
		.i_op  (cmp_op),
		.i_a   (i_opa),
		.i_b   (cmp_b),
		.o_hit (cmp_hit)
	);

	// Register file over APB
	cmp_apb_regs u_regs
	(
		.i_clk     (i_clk),
		.i_reset   (i_reset),
		.i_ce      (i_ce),
		.i_psel    (i_psel),
		.i_penable (i_penable),
		.i_pwrite  (i_pwrite),
		.i_paddr   (i_paddr),
		.i_pwdata  (i_pwdata),
		.i_busy    (state_r == ST_CUSTOM),
		.i_cmp_evt (accept && is_cmp),
		.i_ci_evt  (accept && is_ci),
		.o_prdata  (o_prdata),
		.o_pready  (o_pready),
		.o_pslverr (o_pslverr),
		.o_enable  (enable)
	);

	// Sequencer next state
	always_comb
	begin
		state_nxt    = state_r;
		wb_valid_nxt = 1'b0;
		wb_idx_nxt   = wb_idx_r;
		wb_data_nxt  = wb_data_r;
		unh_nxt      = 1'b0;
		start_nxt    = 1'b0;
		n_nxt        = n_r;
		da_nxt       = da_r;
		db_nxt       = db_r;
		ca_nxt       = ca_r;
		cb_nxt       = cb_r;
		cc_nxt       = cc_r;
		rra_nxt      = rra_r;
		rrb_nxt      = rrb_r;
		wrc_nxt      = wrc_r;
		case (state_r)
			ST_IDLE:
			begin
				if (accept && is_cmp)
				begin
					wb_valid_nxt = 1'b1;
					wb_idx_nxt   = cmp_dst;
					wb_data_nxt  = {31'h0000_0000, cmp_hit};
				end
				else if (accept && is_ci)
				begin
					// selector and indices to user logic
					start_nxt = 1'b1;
					n_nxt     = i_instr[cmp_decode_pkg::FLD_N_LSB +: 8];
					da_nxt    = i_opa;
					db_nxt    = i_opb;
					ca_nxt    = reg_idx(i_instr, cmp_decode_pkg::FLD_A_LSB);
					cb_nxt    = reg_idx(i_instr, cmp_decode_pkg::FLD_B_LSB);
					cc_nxt    = reg_idx(i_instr, cmp_decode_pkg::FLD_C_LSB);
					rra_nxt   = i_instr[cmp_decode_pkg::FLD_READRA];
					rrb_nxt   = i_instr[cmp_decode_pkg::FLD_READRB];
					wrc_nxt   = i_instr[cmp_decode_pkg::FLD_WRITERC];
					state_nxt = ST_CUSTOM;
				end
				else if (accept)
				begin
					unh_nxt = 1'b1;
				end
			end
			ST_CUSTOM:
			begin
				if (i_ci_done)
				begin
					// else result stays in custom file
					wb_valid_nxt = wrc_r;
					wb_idx_nxt   = wrc_r ? cc_r : wb_idx_r;
					wb_data_nxt  = wrc_r ? i_ci_result : wb_data_r;
					state_nxt    = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		ready_nxt = (state_nxt == ST_IDLE) && enable;
	end

	// Sequencer registers
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			state_r    <= ST_IDLE;
			ready_r    <= 1'b0;
			wb_valid_r <= 1'b0;
			wb_idx_r   <= 5'h00;
			wb_data_r  <= 32'h0000_0000;
			unh_r      <= 1'b0;
			start_r    <= 1'b0;
			n_r        <= 8'h00;
			da_r       <= 32'h0000_0000;
			db_r       <= 32'h0000_0000;
			ca_r       <= 5'h00;
			cb_r       <= 5'h00;
			cc_r       <= 5'h00;
			rra_r      <= 1'b0;
			rrb_r      <= 1'b0;
			wrc_r      <= 1'b0;
		end
		else if (i_ce)
		begin
			state_r    <= state_nxt;
			ready_r    <= ready_nxt;
			wb_valid_r <= wb_valid_nxt;
			wb_idx_r   <= wb_idx_nxt;
			wb_data_r  <= wb_data_nxt;
			unh_r      <= unh_nxt;
			start_r    <= start_nxt;
			n_r        <= n_nxt;
			da_r       <= da_nxt;
			db_r       <= db_nxt;
			ca_r       <= ca_nxt;
			cb_r       <= cb_nxt;
			cc_r       <= cc_nxt;
			rra_r      <= rra_nxt;
			rrb_r      <= rrb_nxt;
			wrc_r      <= wrc_nxt;
		end
	end

	assign o_issue_ready = ready_r;
	assign o_wb_valid    = wb_valid_r;
	assign o_wb_idx      = wb_idx_r;
	assign o_wb_data     = wb_data_r;
	assign o_unhandled   = unh_r;
	assign o_ci_start    = start_r;
	assign o_ci_n        = n_r;
	assign o_ci_dataa    = da_r;
	assign o_ci_datab    = db_r;
	assign o_ci_a        = ca_r;
	assign o_ci_b        = cb_r;
	assign o_ci_c        = cc_r;
	assign o_ci_readra   = rra_r;
	assign o_ci_readrb   = rrb_r;
	assign o_ci_writerc  = wrc_r;

	// Reference values for the checks below
	logic        go;                        // Taken with clock enabled
	logic        r_form;                    // Valid R-form frame
	logic [31:0] simm;                      // Sign-extended immediate
	logic [31:0] zimm;                      // Zero-extended immediate
	assign go     = accept && i_ce && state_r == ST_IDLE;
	assign r_form = i_instr[5:0] == 6'h3A && i_instr[10:6] == 5'h00;
	assign simm   = {{16{i_instr[21]}}, i_instr[21:6]};
	assign zimm   = {16'h0000, i_instr[21:6]};

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence ci_launch;
		go && i_instr[5:0] == 6'h32;
	endsequence
	sequence ci_finish;
		state_r == ST_CUSTOM && i_ci_done && i_ce;
	endsequence

	a_rform_dest: assert property (go && r_form && is_cmp |=> o_wb_idx == $past(i_instr[21:17]))
		else $error("R-form compare wrote wrong register");
	a_slt_reg: assert property (go && r_form && i_instr[16:11] == 6'h10 |=>
		o_wb_valid && o_wb_data[0] == $past($signed(i_opa) < $signed(i_opb)))
		else $error("signed register compare wrong");
	a_ult_reg: assert property (go && r_form && i_instr[16:11] == 6'h30 |=>
		o_wb_valid && o_wb_data[0] == $past(i_opa < i_opb))
		else $error("unsigned register compare wrong");
	a_ne_reg: assert property (go && r_form && i_instr[16:11] == 6'h18 |=>
		o_wb_valid && o_wb_data[0] == $past(i_opa != i_opb))
		else $error("register not-equal wrong");
	a_iform_dest: assert property (go && !r_form && is_cmp |=> o_wb_idx == $past(i_instr[26:22]))
		else $error("immediate compare wrote wrong register");
	a_slt_imm: assert property (go && i_instr[5:0] == 6'h10 |=>
		o_wb_data[0] == $past($signed(i_opa) < $signed(simm)))
		else $error("signed immediate compare wrong");
	a_ult_imm: assert property (go && i_instr[5:0] == 6'h30 |=>
		o_wb_data[0] == $past(i_opa < zimm))
		else $error("unsigned immediate compare wrong");
	a_ne_imm: assert property (go && i_instr[5:0] == 6'h18 |=>
		o_wb_data[0] == $past(i_opa != simm))
		else $error("immediate not-equal wrong");
	a_ci_launch: assert property (ci_launch |=> o_ci_start && !o_issue_ready ##1 !o_ci_start)
		else $error("custom launch not signalled");
	a_ci_selector: assert property (ci_launch |=> o_ci_n == $past(i_instr[13:6]))
		else $error("custom selector wrong");
	a_ci_writeback: assert property (ci_finish ##0 o_ci_writerc |=>
		o_wb_valid && o_wb_idx == o_ci_c && o_wb_data == $past(i_ci_result))
		else $error("custom result not written");
	a_ci_selbits: assert property (ci_launch |=>
		{o_ci_readra, o_ci_readrb, o_ci_writerc} == $past(i_instr[16:14]))
		else $error("custom select bits wrong");
	a_ci_private: assert property (ci_finish ##0 !o_ci_writerc |=> !o_wb_valid)
		else $error("custom-file result leaked to general file");
	a_upper_zero: assert property (go && is_cmp |=> o_wb_data[31:1] == 31'h0 && !o_unhandled)
		else $error("compare result not clean");

endmodule

/* hdl/cmp_decode_pkg.sv */
package cmp_decode_pkg;

	// Instruction word field positions
	localparam int FLD_A_LSB     = 27;
	localparam int FLD_B_LSB     = 22;
	localparam int FLD_C_LSB     = 17;
	localparam int FLD_OPX_LSB   = 11;
	localparam int FLD_ZERO_LSB  = 6;
	localparam int FLD_IMM_LSB   = 6;
	localparam int FLD_N_LSB     = 6;
	localparam int FLD_READRA    = 16;
	localparam int FLD_READRB    = 15;
	localparam int FLD_WRITERC   = 14;

	// Primary opcodes in bits 5:0
	localparam logic [5:0] OPC_RTYPE   = 6'h3A;
	localparam logic [5:0] OPC_LT_IMM  = 6'h10;
	localparam logic [5:0] OPC_LTU_IMM = 6'h30;
	localparam logic [5:0] OPC_NE_IMM  = 6'h18;
	localparam logic [5:0] OPC_CUSTOM  = 6'h32;

	// Extended opcodes for register form
	localparam logic [5:0] OPX_LT  = 6'h10;
	localparam logic [5:0] OPX_LTU = 6'h30;
	localparam logic [5:0] OPX_NE  = 6'h18;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_CMP_CNT = 8'h08;
	localparam logic [7:0] OFS_CI_CNT  = 8'h0C;

	// Register field positions and reset values
	localparam int         CTRL_EN_BIT   = 0;
	localparam int         STAT_BUSY_BIT = 0;
	localparam logic       CTRL_EN_RST   = 1'b1;
	localparam logic [31:0] CNT_RST      = 32'h0000_0000;

	// Compare kinds handled by the compare unit
	typedef enum logic [1:0] {CMP_LT, CMP_LTU, CMP_NE} cmp_op_t;

endpackage

/* hdl/cmp_unit.sv */
`timescale 1ns/1ps
// Pure compare datapath, one bit result
module cmp_unit
(
	input  wire cmp_decode_pkg::cmp_op_t i_op,   // Compare kind
	input  wire logic [31:0]             i_a,    // Operand A
	input  wire logic [31:0]             i_b,    // Operand B or extended immediate
	output logic                         o_hit   // Compare true
);

	// Select the comparison
	always_comb
	begin
		case (i_op)
			cmp_decode_pkg::CMP_LT:  o_hit = $signed(i_a) < $signed(i_b);
			cmp_decode_pkg::CMP_LTU: o_hit = i_a < i_b;
			cmp_decode_pkg::CMP_NE:  o_hit = i_a != i_b;
			default:                 o_hit = 1'b0;
		endcase
	end

endmodule

/* hdl/cmp_apb_regs.sv */
`timescale 1ns/1ps
// APB slave with control, status and event counters
module cmp_apb_regs
(
	input  wire logic        i_clk,      // Clock
	input  wire logic        i_reset,    // Sync reset, high
	input  wire logic        i_ce,       // Clock enable
	input  wire logic        i_psel,     // APB select
	input  wire logic        i_penable,  // APB enable
	input  wire logic        i_pwrite,   // APB write
	input  wire logic [7:0]  i_paddr,    // APB address
	input  wire logic [31:0] i_pwdata,   // APB write data
	input  wire logic        i_busy,     // Custom op in flight
	input  wire logic        i_cmp_evt,  // Compare retired pulse
	input  wire logic        i_ci_evt,   // Custom launched pulse
	output logic [31:0]      o_prdata,   // APB read data
	output logic             o_pready,   // APB ready
	output logic             o_pslverr,  // APB error
	output logic             o_enable    // Issue enable
);

	logic [31:0] prdata_r, prdata_nxt;     // Read data
	logic        pready_r, pready_nxt;     // Ready
	logic        pslverr_r, pslverr_nxt;   // Error
	logic        en_r, en_nxt;             // Control enable
	logic [31:0] cmp_cnt_r, cmp_cnt_nxt;   // Compares retired
	logic [31:0] ci_cnt_r, ci_cnt_nxt;     // Custom ops launched
	logic        setup;                    // Setup phase seen
	logic        mapped;                   // Address decodes

	// Next state: answer one cycle after setup
	always_comb
	begin
		setup       = i_psel && !i_penable;
		mapped      = (i_paddr == cmp_decode_pkg::OFS_CTRL) ||
		              (i_paddr == cmp_decode_pkg::OFS_STATUS) ||
		              (i_paddr == cmp_decode_pkg::OFS_CMP_CNT) ||
		              (i_paddr == cmp_decode_pkg::OFS_CI_CNT);
		pready_nxt  = setup;
		pslverr_nxt = setup && !mapped;
		prdata_nxt  = 32'h0000_0000;
		en_nxt      = en_r;
		cmp_cnt_nxt = cmp_cnt_r + {31'h0000_0000, i_cmp_evt};
		ci_cnt_nxt  = ci_cnt_r + {31'h0000_0000, i_ci_evt};
		// Read data captured at setup
		if (setup && !i_pwrite)
		begin
			case (i_paddr)
				cmp_decode_pkg::OFS_CTRL:
					prdata_nxt[cmp_decode_pkg::CTRL_EN_BIT] = en_r;
				cmp_decode_pkg::OFS_STATUS:
					prdata_nxt[cmp_decode_pkg::STAT_BUSY_BIT] = i_busy;
				cmp_decode_pkg::OFS_CMP_CNT: prdata_nxt = cmp_cnt_r;
				cmp_decode_pkg::OFS_CI_CNT:  prdata_nxt = ci_cnt_r;
				default:                     prdata_nxt = 32'h0000_0000;
			endcase
		end
		// Write takes effect in the completing access cycle
		if (i_psel && i_penable && pready_r && i_pwrite &&
		    i_paddr == cmp_decode_pkg::OFS_CTRL)
		begin
			en_nxt = i_pwdata[cmp_decode_pkg::CTRL_EN_BIT];
		end
	end

	// Registers
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			en_r      <= cmp_decode_pkg::CTRL_EN_RST;
			cmp_cnt_r <= cmp_decode_pkg::CNT_RST;
			ci_cnt_r  <= cmp_decode_pkg::CNT_RST;
		end
		else if (i_ce)
		begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			en_r      <= en_nxt;
			cmp_cnt_r <= cmp_cnt_nxt;
			ci_cnt_r  <= ci_cnt_nxt;
		end
	end

	assign o_prdata  = prdata_r;
	assign o_pready  = pready_r;
	assign o_pslverr = pslverr_r;
	assign o_enable  = en_r;

endmodule

/* test/cust_model.sv */
`timescale 1ns/1ps
// Stand-in for the user custom function logic
module cust_model
(
	input  wire logic        i_clk,     // Clock
	input  wire logic        i_reset,   // Sync reset, high
	input  wire logic        i_start,   // Launch pulse
	input  wire logic [7:0]  i_n,       // Function selector
	input  wire logic [31:0] i_dataa,   // Operand A
	input  wire logic [31:0] i_datab,   // Operand B
	output logic             o_done,    // Result pulse
	output logic [31:0]      o_result   // Result value
);
	logic [3:0]  cnt_r;  // Cycles left before done
	logic [31:0] res_r;  // Held result

	always_ff @(posedge i_clk)
	begin
		o_done <= 1'b0;
		if (i_reset)
			cnt_r <= 4'h0;
		else if (i_start)
		begin
			// Latency 1 to 8 cycles, prompt or slow
			cnt_r <= {1'b0, i_n[2:0]} + 4'h1;
			res_r <= i_dataa ^ i_datab ^ {24'h000000, i_n};
		end
		else if (cnt_r != 4'h0)
		begin
			cnt_r  <= cnt_r - 4'h1;
			o_done <= (cnt_r == 4'h1);
		end
	end

	// Result line shows garbage outside the done pulse
	assign o_result = o_done ? res_r : ~res_r;
endmodule

/* test/compare_and_custom_decode_bench.sv */
`timescale 1ns/1ps
// Self-checking bench for the compare and custom slice
module compare_and_custom_decode_bench;
	logic        i_clk, i_reset, i_ce, i_psel, i_penable, i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata, o_prdata, i_instr, i_opa, i_opb, o_wb_data;
	logic [31:0] o_ci_dataa, o_ci_datab, i_ci_result;
	logic        o_pready, o_pslverr, i_issue_valid, o_issue_ready, o_wb_valid;
	logic        o_unhandled, o_ci_start, o_ci_readra, o_ci_readrb, o_ci_writerc, i_ci_done;
	logic [4:0]  o_wb_idx, o_ci_a, o_ci_b, o_ci_c;
	logic [7:0]  o_ci_n;
	int          error_cnt, n_checks, i, j;
	logic [31:0] rd, va [3], ia [3];          // Read data and operand tables
	logic        err;                        // Last APB error
	logic [5:0]  opx [3];                    // Compare opcodes

	compare_and_custom_decode i_compare_and_custom_decode (.i_clk(i_clk), .i_reset(i_reset),
		.i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
		.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_issue_valid(i_issue_valid), .i_instr(i_instr),
		.i_opa(i_opa), .i_opb(i_opb), .o_issue_ready(o_issue_ready), .o_wb_valid(o_wb_valid),
		.o_wb_idx(o_wb_idx), .o_wb_data(o_wb_data), .o_unhandled(o_unhandled),
		.o_ci_start(o_ci_start), .o_ci_n(o_ci_n), .o_ci_dataa(o_ci_dataa),
		.o_ci_datab(o_ci_datab), .o_ci_a(o_ci_a), .o_ci_b(o_ci_b), .o_ci_c(o_ci_c),
		.o_ci_readra(o_ci_readra), .o_ci_readrb(o_ci_readrb), .o_ci_writerc(o_ci_writerc),
		.i_ci_done(i_ci_done), .i_ci_result(i_ci_result));
	cust_model i_cust_model (.i_clk(i_clk), .i_reset(i_reset), .i_start(o_ci_start),
		.i_n(o_ci_n), .i_dataa(o_ci_dataa), .i_datab(o_ci_datab),
		.o_done(i_ci_done), .o_result(i_ci_result));

	// Clock 40 MHz
	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	// Compare a value with its expectation
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up;
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One APB transfer, wait for pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	endtask

	// Offer one word, then wait for its outcome
	task automatic issue(input logic [31:0] ins, a, b);
		int k;
		i_issue_valid <= 1'b1;
		i_instr <= ins;
		i_opa <= a;
		i_opb <= b;
		do @(posedge i_clk); while (o_issue_ready !== 1'b1);
		i_issue_valid <= 1'b0;
		k = 0;
		do @(posedge i_clk); while (!(o_wb_valid | o_unhandled | o_ci_start) && ++k < 4);
	endtask

	// Wait a bounded time for a write-back pulse
	task automatic wait_wb(output logic seen);
		seen = 1'b0;
		repeat (14)
		begin
			@(posedge i_clk);
			seen |= o_wb_valid;
			if (o_wb_valid)
				break;
		end
	endtask

	// Compare result worked out here
	function automatic logic [31:0] ref_cmp(input logic [5:0] op, input logic [31:0] a, b);
		if (op == 6'h10)
			return {31'h0, $signed(a) < $signed(b)};
		if (op == 6'h30)
			return {31'h0, a < b};
		return {31'h0, a != b};
	endfunction

	// Watchdog
	initial
	begin
		#(25 * 20000);
		error_cnt++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		{i_ce, i_reset} = 2'b11;
		{i_psel, i_penable, i_pwrite, i_issue_valid} = 4'h0;
		{i_paddr, i_pwdata, i_instr, i_opa, i_opb} = '0;
		opx = '{6'h10, 6'h30, 6'h18};
		va = '{32'h80000000, 32'h00000001, 32'hFFFFFFFF};
		ia = '{32'h0000FFFF, 32'h00008000, 32'h00000001};
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl reset", rd, 32'h00000001);
		chk("ctrl no err", err, 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		chk("cmp count reset", rd, 32'h00000000);
		for (i = 0; i < 3; i++)
			for (j = 0; j < 3; j++)
			begin
				issue({5'h03, 5'h04, 5'h1F - 5'(j), opx[i], 5'h00, 6'h3A}, va[j], va[(j + 1) % 3]);
				chk("r wb", o_wb_valid, 1'b1);
				chk("r idx", o_wb_idx, 5'h1F - 5'(j));
				chk("r data", o_wb_data, ref_cmp(opx[i], va[j], va[(j + 1) % 3]));
			end
		issue({5'h03, 5'h04, 5'h05, 6'h18, 5'h00, 6'h3A}, 32'h5A5A5A5A, 32'h5A5A5A5A);
		chk("r ne equal", o_wb_data, 32'h00000000);
		// immediate form, sign or zero extension
		for (i = 0; i < 3; i++)
			for (j = 0; j < 3; j++)
			begin
				issue({5'h05, 5'h11, ia[j][15:0], opx[i]}, va[j], 32'h12345678);
				chk("i wb", o_wb_valid, 1'b1);
				chk("i idx", o_wb_idx, 5'h11);
				rd = (opx[i] == 6'h30) ? ia[j] : {{16{ia[j][15]}}, ia[j][15:0]};
				chk("i data", o_wb_data, ref_cmp(opx[i], va[j], rd));
			end
		issue({5'h05, 5'h11, 16'hFFFF, 6'h18}, 32'hFFFFFFFF, 32'h0);
		chk("i ne equal", o_wb_data, 32'h00000000);
		// Unsigned <= 65534 built as < 65535
		for (i = 0; i < 2; i++)
		begin
			issue({5'h02, 5'h06, 16'hFFFF, 6'h30}, 32'h0000FFFE + 32'(i), 32'h0);
			chk("le imm", o_wb_data, 32'(1 - i));
		end
		// Nonzero spare field and foreign extended opcode
		issue({5'h01, 5'h02, 5'h03, 6'h10, 5'h01, 6'h3A}, 32'h0, 32'h1);
		chk("spare bits", o_unhandled, 1'b1);
		chk("spare no wb", o_wb_valid, 1'b0);
		issue({5'h01, 5'h02, 5'h03, 6'h08, 5'h00, 6'h3A}, 32'h0, 32'h1);
		chk("other opx", o_unhandled, 1'b1);
		// Custom with general destination, selector 0xA5
		issue({5'h07, 5'h08, 5'h09, 3'b101, 8'hA5, 6'h32}, 32'hCAFE0001, 32'h0F0F0F0F);
		chk("ci start", o_ci_start, 1'b1);
		chk("ci n", o_ci_n, 8'hA5);
		chk("ci dataa", o_ci_dataa, 32'hCAFE0001);
		chk("ci datab", o_ci_datab, 32'h0F0F0F0F);
		chk("ci idx", {o_ci_a, o_ci_b, o_ci_c}, {5'h07, 5'h08, 5'h09});
		chk("ci sel", {o_ci_readra, o_ci_readrb, o_ci_writerc}, 3'b101);
		chk("ci busy", o_issue_ready, 1'b0);
		apb(1'b0, 8'h04, 32'h0);
		chk("status busy", rd, 32'h00000001);
		wait_wb(err);
		chk("ci wb", err, 1'b1);
		chk("ci wb idx", o_wb_idx, 5'h09);
		chk("ci wb data", o_wb_data, 32'hC5F10F0E ^ 32'hA5);
		// Custom into the custom file, selector 0
		issue({5'h0A, 5'h0B, 5'h0C, 3'b010, 8'h00, 6'h32}, 32'h1, 32'h2);
		chk("ci n0", o_ci_n, 8'h00);
		chk("ci sel2", {o_ci_readra, o_ci_readrb, o_ci_writerc}, 3'b010);
		wait_wb(err);
		chk("no ci wb", err, 1'b0);
		chk("ready back", o_issue_ready, 1'b1);
		// Registers: counts, unmapped, disable
		apb(1'b0, 8'h08, 32'h0);
		chk("cmp count", rd, 32'h00000016);
		apb(1'b0, 8'h04, 32'h0);
		chk("status idle", rd, 32'h00000000);
		apb(1'b0, 8'h0C, 32'h0);
		chk("ci count", rd, 32'h00000002);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", err, 1'b1);
		chk("unmapped rd", rd, 32'h00000000);
		apb(1'b1, 8'h00, 32'h0);
		@(posedge i_clk);
		chk("disabled", o_issue_ready, 1'b0);
		apb(1'b1, 8'h00, 32'h1);
		@(posedge i_clk);
		chk("enabled", o_issue_ready, 1'b1);
		wrap_up();
	end
endmodule
